// file: inc/mss_pkg.sv
package mss_pkg;

  // Clock and the quarter-second base tick that all blink and hold timing uses.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned QTR_MS = 250;
  localparam int unsigned QTR_CYCLES = (CLK_HZ / 1000) * QTR_MS;
  localparam int unsigned QTRS_PER_S = 1000 / QTR_MS;

  // Sequence timing in its own unit and then in quarter ticks, the steady phase count, and the grace period in hours and seconds.
  localparam int unsigned BOOT_MS = 1000;
  localparam int unsigned BOOT_QTRS = BOOT_MS / QTR_MS;
  localparam int unsigned OFFER_WINDOW_S = 10;
  localparam int unsigned OFFER_QTRS = OFFER_WINDOW_S * QTRS_PER_S;
  localparam int unsigned PHASE_MS = 2500;
  localparam int unsigned PHASE_QTRS = PHASE_MS / QTR_MS;
  localparam int unsigned CONFIRM_MS = 3000;
  localparam int unsigned CONFIRM_QTRS = CONFIRM_MS / QTR_MS;
  localparam int unsigned STEADY_TARGET = 6;
  localparam int unsigned GRACE_HOURS = 72;
  localparam int unsigned GRACE_SECONDS = GRACE_HOURS * 3600;

  // Switch debounce time.
  localparam int unsigned DEB_US = 10_000;
  localparam int unsigned DEB_CYCLES = (CLK_HZ / 1_000_000) * DEB_US;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FW_VERSION = 8'h08;
  localparam logic [7:0] REG_FEAT_CODE = 8'h0C;
  localparam logic [7:0] REG_FEAT_SERIAL = 8'h10;
  localparam logic [7:0] REG_STATION_ADDR = 8'h14;
  localparam logic [7:0] REG_PROG_IP = 8'h18;
  localparam logic [7:0] REG_GRACE_LEFT = 8'h1C;

  // Field positions and reset values.
  localparam int unsigned CTRL_OVR_RESET_BIT = 0;
  localparam int unsigned STATUS_FEAT_BIT = 4;
  localparam int unsigned STATUS_GRACE_BIT = 5;
  localparam int unsigned STATUS_EXPIRED_BIT = 6;
  localparam int unsigned STATUS_CARD_BIT = 7;
  localparam int unsigned STATUS_RUN_BIT = 8;
  localparam logic [6:0] STATION_ADDR_DEFAULT = 7'h02;
  localparam logic [31:0] PROG_IP_DEFAULT = 32'h00000000;
  localparam logic [15:0] FW_VERSION_DEFAULT = 16'h0100;

  // Package name characters.
  localparam logic [7:0] CHAR_P = 8'h70;
  localparam logic [7:0] CHAR_B = 8'h62;
  localparam logic [7:0] CHAR_0 = 8'h30;
  localparam logic [7:0] CHAR_9 = 8'h39;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_BOOT, ST_SCAN, ST_OFFER, ST_OFFER_TIP, ST_UPD_BUSY, ST_UPD_OK, ST_UPD_ERR,
    ST_IDLE, ST_HOLD, ST_ARMED, ST_FR_CLEAR, ST_FR_CONFIRM, ST_FR_DONE
  } mss_phase_type;

  // What the card reader reports about the inserted card.
  typedef struct packed {
    logic [63:0] name;
    logic [15:0] version;
    logic [31:0] serial;
  } mss_card_type;

  // Answers from the firmware loader and the RAM clearing engine.
  typedef struct packed {
    logic xfer_done;
    logic xfer_err;
    logic ram_done;
    logic ram_ok;
  } mss_engine_type;

endpackage

// file: hw/mss_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module mss_debounce #(
  parameter int unsigned W = 3,
  parameter int unsigned DEB_CYCLES = 2_500_000
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pins and their clean levels.
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  import mss_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
    logic [31:0] cnt;
  } mss_deb_type;

  mss_deb_type deb_r;
  mss_deb_type deb_nxt;

  // Three-stage sampling; a change counts once stages two and three agree and stay put.
  always_comb
  begin
    deb_nxt = deb_r;
    deb_nxt.s1 = pin_i;
    deb_nxt.s2 = deb_r.s1;
    deb_nxt.s3 = deb_r.s2;
    if (deb_r.s2 != deb_r.s3 || deb_r.s3 == deb_r.level)
    begin
      deb_nxt.cnt = 32'h00000000;
    end
    else if (deb_r.cnt == 32'(DEB_CYCLES - 1))
    begin
      deb_nxt.level = deb_r.s3;
      deb_nxt.cnt = 32'h00000000;
    end
    else
    begin
      deb_nxt.cnt = deb_r.cnt + 32'h00000001;
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      deb_r <= '0;
    end
    else
    begin
      deb_r <= deb_nxt;
    end
  end

  assign level_o = deb_r.level;
endmodule
`default_nettype wire

// file: hw/mss_sequencer.sv
// Overview of operation
// RL1: Power-on at STOP searches card for firmware.
// RL2: Offer update only when package version differs.
// RL3: Package name is pb plus six digits.
// RL4: Offer shown by alternating red and yellow.
// RL5: Start only after tip to reset within 10s.
// RL6: Yellow flickers while update runs.
// RL7: Success: red and yellow flash together 1Hz.
// RL8: Failure: only red flashes, yellow off.
// RL9: Every update includes an overall reset.
// RL10: Reset hold: blink, steady, alternating phases.
// RL11: Factory reset after sixth steady, then tip.
// RL12: Yellow blinks 2Hz confirming RAM cleared.
// RL13: Wrong count: overall reset, steady yellow.
// RL14: Factory reset restores address 2, IP zero.
// RL15: Factory reset done: both LEDs 1Hz.
// RL16: Card command may request factory reset.
// RL17: Missing feature card: red blink, 72h countdown; red blinks only while the CPU runs.
// RL18: Reinserted feature card clears warning.
// RL19: Check card after power-on and overall reset.
// RL20: Features activate only on overall reset; feature_set_code_o follows REG_FEAT_CODE writes at once while active.
// RL21: Activation code bound to card serial number.
// RL22: Switch debounced; window timed from offer.
`timescale 1ns/10ps
`default_nettype none
module mss_sequencer #(
  parameter int unsigned QTR_CYCLES = mss_pkg::QTR_CYCLES,
  parameter int unsigned DEB_CYCLES = mss_pkg::DEB_CYCLES,
  parameter int unsigned GRACE_SECONDS = mss_pkg::GRACE_SECONDS,
  parameter logic [47:0] PKG_DIGITS = 48'h303030303031
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Mode switch and card slot pins.
  input wire logic sw_run_i,
  input wire logic sw_mres_i,
  input wire logic card_present_i,
  // Card reader.
  output logic scan_req_o,
  input wire logic scan_done_i,
  input wire mss_pkg::mss_card_type card_i,
  // Firmware loader, RAM clearing engine and command file interpreter.
  output logic fw_start_o,
  output logic ovr_reset_o,
  output logic fac_reset_o,
  input wire mss_pkg::mss_engine_type eng_i,
  input wire logic cmd_factory_i,
  // Status LEDs and CPU state.
  output logic led_red_o,
  output logic led_yellow_o,
  output logic cpu_run_o,
  output logic feat_active_o,
  output logic [15:0] feature_set_code_o,
  output logic [6:0] station_bus_address_o,
  output logic [31:0] programming_channel_ip_o,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  import mss_pkg::*;

  typedef struct packed {
    mss_phase_type st;
    logic [31:0] qdiv;
    logic [1:0] blink;
    logic [7:0] tmr;
    logic in_steady;
    logic [2:0] steady_cnt;
    logic fail_steady;
    logic stop_prev;
    logic feat_active;
    logic [15:0] feat_code;
    logic [31:0] feat_serial;
    logic [15:0] fw_version;
    logic [6:0] station;
    logic [31:0] prog_ip;
    logic [31:0] grace_s;
    logic grace_expired;
    logic scan_req;
    logic fw_start;
    logic ovr_reset;
    logic fac_reset;
    logic led_red;
    logic led_yellow;
    logic run;
    logic [31:0] rdata;
  } mss_core_type;

  mss_core_type core_r;
  mss_core_type core_nxt;
  logic [2:0] pins_clean;
  logic sw_run;
  logic sw_mres;
  logic sw_stop;
  logic card_in;
  logic qtick;
  logic stick;
  logic card_ok;

  // Checks a card file name against the reserved package name of this revision.
  function automatic logic pkg_name_ok(input logic [63:0] name);
    logic ok;
    ok = (name[63:56] == CHAR_P) && (name[55:48] == CHAR_B); // RL3
    for (int i = 0; i < 6; i++)
    begin
      ok = ok && (name[i*8 +: 8] >= CHAR_0) && (name[i*8 +: 8] <= CHAR_9); // RL3
    end
    return ok && (name[47:0] == PKG_DIGITS); // RL3
  endfunction

  // Switch and slot pins are synchronised and debounced before use.
  mss_debounce #(
    .W(3),
    .DEB_CYCLES(DEB_CYCLES)
  ) u_debounce (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({card_present_i, sw_mres_i, sw_run_i}),
    .level_o(pins_clean)
  ); // RL22

  // Decoded switch position and tick enables.
  assign sw_run = pins_clean[0] && !pins_clean[1];
  assign sw_mres = pins_clean[1];
  assign sw_stop = !pins_clean[0] && !pins_clean[1];
  assign card_in = pins_clean[2];
  assign qtick = (core_r.qdiv == 32'(QTR_CYCLES - 1));
  assign stick = qtick && (core_r.blink == 2'h3);
  assign card_ok = card_in && (card_i.serial == core_r.feat_serial); // RL21

  // Sequencer, LED drive, feature guard and register file.
  always_comb
  begin
    core_nxt = core_r;
    core_nxt.scan_req = 1'b0;
    core_nxt.fw_start = 1'b0;
    core_nxt.ovr_reset = 1'b0;
    core_nxt.fac_reset = 1'b0;
    core_nxt.stop_prev = sw_stop;
    core_nxt.qdiv = qtick ? 32'h00000000 : core_r.qdiv + 32'h00000001;
    if (qtick)
    begin
      core_nxt.blink = core_r.blink + 2'h1;
      core_nxt.tmr = core_r.tmr + 8'h01;
    end
    case (core_r.st)
      ST_BOOT:
      begin
        if (core_r.tmr == 8'(BOOT_QTRS))
        begin
          core_nxt.scan_req = 1'b1; // RL19
          core_nxt.st = ST_SCAN;
        end
      end
      ST_SCAN:
      begin
        if (scan_done_i)
        begin
          core_nxt.tmr = 8'h00;
          if (sw_stop && pkg_name_ok(card_i.name) // RL1
              && card_i.version != core_r.fw_version) // RL2
          begin
            core_nxt.st = ST_OFFER;
          end
          else
          begin
            core_nxt.st = ST_IDLE;
          end
        end
      end
      ST_OFFER:
      begin
        if (sw_mres)
        begin
          core_nxt.st = ST_OFFER_TIP; // RL5
        end
        else if (core_r.tmr == 8'(OFFER_QTRS))
        begin
          core_nxt.st = ST_IDLE; // RL22
        end
      end
      ST_OFFER_TIP:
      begin
        if (sw_stop)
        begin
          core_nxt.fw_start = 1'b1; // RL5
          core_nxt.ovr_reset = 1'b1; // RL9
          core_nxt.st = ST_UPD_BUSY;
        end
        else if (sw_run)
        begin
          core_nxt.st = ST_IDLE;
        end
      end
      ST_UPD_BUSY:
      begin
        if (eng_i.xfer_err)
        begin
          core_nxt.st = ST_UPD_ERR;
        end
        else if (eng_i.xfer_done)
        begin
          core_nxt.st = ST_UPD_OK;
        end
      end
      ST_IDLE:
      begin
        if (cmd_factory_i)
        begin
          core_nxt.fac_reset = 1'b1; // RL16
          core_nxt.st = ST_FR_CLEAR;
        end
        else if (sw_mres && core_r.stop_prev)
        begin
          core_nxt.st = ST_HOLD;
          core_nxt.tmr = 8'h00;
          core_nxt.in_steady = 1'b0;
          core_nxt.steady_cnt = 3'h0;
          core_nxt.fail_steady = 1'b0;
        end
        else if (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_OVR_RESET_BIT])
        begin
          core_nxt.ovr_reset = 1'b1;
          core_nxt.fail_steady = 1'b0;
        end
      end
      ST_HOLD:
      begin
        if (!sw_mres)
        begin
          if (core_r.steady_cnt == 3'(STEADY_TARGET))
          begin
            core_nxt.st = ST_ARMED; // RL11
          end
          else
          begin
            core_nxt.ovr_reset = 1'b1; // RL13
            core_nxt.fail_steady = 1'b1; // RL13
            core_nxt.st = ST_IDLE;
          end
        end
        else if (qtick && core_r.tmr == 8'(PHASE_QTRS - 1))
        begin
          core_nxt.tmr = 8'h00;
          core_nxt.in_steady = !core_r.in_steady; // RL10
          if (!core_r.in_steady && core_r.steady_cnt != 3'h7)
          begin
            core_nxt.steady_cnt = core_r.steady_cnt + 3'h1; // RL10
          end
        end
      end
      ST_ARMED:
      begin
        if (sw_mres)
        begin
          core_nxt.fac_reset = 1'b1; // RL11
          core_nxt.st = ST_FR_CLEAR;
        end
        else if (sw_run)
        begin
          core_nxt.st = ST_IDLE;
        end
      end
      ST_FR_CLEAR:
      begin
        if (eng_i.ram_done && eng_i.ram_ok)
        begin
          core_nxt.station = STATION_ADDR_DEFAULT; // RL14
          core_nxt.prog_ip = PROG_IP_DEFAULT; // RL14
          core_nxt.tmr = 8'h00;
          core_nxt.st = ST_FR_CONFIRM;
        end
        else if (eng_i.ram_done)
        begin
          core_nxt.ovr_reset = 1'b1; // RL13
          core_nxt.fail_steady = 1'b1;
          core_nxt.st = ST_IDLE;
        end
      end
      ST_FR_CONFIRM:
      begin
        if (core_r.tmr == 8'(CONFIRM_QTRS))
        begin
          core_nxt.st = ST_FR_DONE;
        end
      end
      ST_UPD_OK, ST_UPD_ERR, ST_FR_DONE:
      begin
        core_nxt.st = core_r.st;
      end
      default:
      begin
        core_nxt.st = ST_IDLE;
      end
    endcase
    // Each overall reset checks the card and evaluates feature activation.
    if (core_nxt.ovr_reset)
    begin
      core_nxt.scan_req = 1'b1; // RL19
      core_nxt.feat_active = card_ok && (core_r.feat_code != 16'h0000); // RL20
    end
    // Grace countdown while activated features miss their card.
    if (core_r.feat_active && !card_ok)
    begin
      if (stick && core_r.grace_s != 32'h00000000)
      begin
        core_nxt.grace_s = core_r.grace_s - 32'h00000001; // RL17
      end
      if (core_r.grace_s == 32'h00000000)
      begin
        core_nxt.grace_expired = 1'b1; // RL17
      end
    end
    else
    begin
      core_nxt.grace_s = 32'(GRACE_SECONDS); // RL18
      core_nxt.grace_expired = 1'b0; // RL18
    end
    core_nxt.run = (core_nxt.st == ST_IDLE) && sw_run && !core_nxt.grace_expired; // RL17
    // LED patterns per state; blink[0] is 2Hz and blink[1] is 1Hz.
    case (core_nxt.st)
      ST_OFFER, ST_OFFER_TIP:
      begin
        core_nxt.led_red = core_nxt.blink[0]; // RL4
        core_nxt.led_yellow = !core_nxt.blink[0]; // RL4
      end
      ST_UPD_BUSY:
      begin
        core_nxt.led_red = 1'b0;
        core_nxt.led_yellow = core_nxt.blink[0]; // RL6
      end
      ST_UPD_OK, ST_FR_DONE:
      begin
        core_nxt.led_red = core_nxt.blink[1]; // RL7 RL15
        core_nxt.led_yellow = core_nxt.blink[1]; // RL7 RL15
      end
      ST_UPD_ERR:
      begin
        core_nxt.led_red = core_nxt.blink[1]; // RL8
        core_nxt.led_yellow = 1'b0; // RL8
      end
      ST_HOLD:
      begin
        core_nxt.led_red = 1'b0;
        core_nxt.led_yellow = core_nxt.in_steady || core_nxt.blink[0]; // RL10
      end
      ST_FR_CONFIRM:
      begin
        core_nxt.led_red = 1'b0;
        core_nxt.led_yellow = core_nxt.blink[0]; // RL12
      end
      default:
      begin
        core_nxt.led_red = core_nxt.run && core_r.feat_active && !card_ok
                           && core_nxt.blink[1]; // RL17
        core_nxt.led_yellow = core_nxt.fail_steady; // RL13
      end
    endcase
    // Register writes.
    if (wr_i)
    begin
      case (addr_i)
        REG_FW_VERSION: core_nxt.fw_version = wdata_i[15:0];
        REG_FEAT_CODE: core_nxt.feat_code = wdata_i[15:0];
        REG_FEAT_SERIAL: core_nxt.feat_serial = wdata_i;
        REG_STATION_ADDR: core_nxt.station = wdata_i[6:0];
        REG_PROG_IP: core_nxt.prog_ip = wdata_i;
        default: core_nxt.rdata = core_nxt.rdata;
      endcase
    end
    // Register reads answer in the next cycle only.
    core_nxt.rdata = 32'h00000000;
    if (rd_i)
    begin
      case (addr_i)
        REG_STATUS:
        begin
          core_nxt.rdata[3:0] = core_r.st;
          core_nxt.rdata[STATUS_FEAT_BIT] = core_r.feat_active;
          core_nxt.rdata[STATUS_GRACE_BIT] = core_r.feat_active && !card_ok;
          core_nxt.rdata[STATUS_EXPIRED_BIT] = core_r.grace_expired;
          core_nxt.rdata[STATUS_CARD_BIT] = card_in;
          core_nxt.rdata[STATUS_RUN_BIT] = core_r.run;
        end
        REG_FW_VERSION: core_nxt.rdata[15:0] = core_r.fw_version;
        REG_FEAT_CODE: core_nxt.rdata[15:0] = core_r.feat_code;
        REG_FEAT_SERIAL: core_nxt.rdata = core_r.feat_serial;
        REG_STATION_ADDR: core_nxt.rdata[6:0] = core_r.station;
        REG_PROG_IP: core_nxt.rdata = core_r.prog_ip;
        REG_GRACE_LEFT: core_nxt.rdata = core_r.grace_s;
        default: core_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // State register with delivery defaults.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_r <= '0;
      core_r.st <= ST_BOOT;
      core_r.fw_version <= FW_VERSION_DEFAULT;
      core_r.station <= STATION_ADDR_DEFAULT;
      core_r.prog_ip <= PROG_IP_DEFAULT;
      core_r.grace_s <= 32'(GRACE_SECONDS);
    end
    else
    begin
      core_r <= core_nxt;
    end
  end

  // Outputs straight from the state register.
  assign scan_req_o = core_r.scan_req;
  assign fw_start_o = core_r.fw_start;
  assign ovr_reset_o = core_r.ovr_reset;
  assign fac_reset_o = core_r.fac_reset;
  assign led_red_o = core_r.led_red;
  assign led_yellow_o = core_r.led_yellow;
  assign cpu_run_o = core_r.run;
  assign feat_active_o = core_r.feat_active;
  assign feature_set_code_o = core_r.feat_active ? core_r.feat_code : 16'h0000;
  assign station_bus_address_o = core_r.station;
  assign programming_channel_ip_o = core_r.prog_ip;
  assign rdata_o = core_r.rdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Checks on the sequencer.
  no_same_offer_a: assert property ((core_r.st == ST_SCAN && scan_done_i
    && card_i.version == core_r.fw_version) |=> core_r.st != ST_OFFER) // RL2
    else $error("update offered for an equal version");
  start_after_tip_a: assert property (fw_start_o |-> $past(core_r.st) == ST_OFFER_TIP // RL5
    && $past(core_r.st, 2) inside {ST_OFFER, ST_OFFER_TIP})
    else $error("firmware start without switch tip");
  update_resets_a: assert property (fw_start_o |-> ovr_reset_o && scan_req_o) // RL9
    else $error("update without overall reset");
  err_red_only_a: assert property (core_r.st == ST_UPD_ERR |=> !led_yellow_o) // RL8
    else $error("yellow lit on update error");
  ok_both_a: assert property (core_r.st == ST_UPD_OK |=> led_red_o == led_yellow_o) // RL7
    else $error("success LEDs not together");
  factory_armed_a: assert property (fac_reset_o |-> $past(core_r.st) inside {ST_ARMED, ST_IDLE}) // RL11
    else $error("factory reset from wrong state");
  delivery_state_a: assert property ((core_r.st == ST_FR_CLEAR && eng_i.ram_done && eng_i.ram_ok)
    |=> station_bus_address_o == 7'h02 && programming_channel_ip_o == 32'h00000000) // RL14
    else $error("delivery state not restored");
  expired_stop_a: assert property (core_r.grace_expired |-> !cpu_run_o) // RL17
    else $error("cpu runs after grace expiry");
  card_back_a: assert property ((core_r.feat_active && card_ok) |=> !core_r.grace_expired) // RL18
    else $error("warning kept with card present");
  bad_count_a: assert property ((core_r.st == ST_HOLD && !sw_mres
    && core_r.steady_cnt != 3'h6) |=> ovr_reset_o ##1 led_yellow_o) // RL13
    else $error("wrong count did not show steady yellow");

  offer_seen_c: cover property (core_r.st == ST_OFFER ##1 core_r.st == ST_OFFER_TIP);
  update_ok_c: cover property (core_r.st == ST_UPD_BUSY ##1 core_r.st == ST_UPD_OK);
  factory_done_c: cover property (core_r.st == ST_FR_CONFIRM ##1 core_r.st == ST_FR_DONE);
  grace_out_c: cover property ($rose(core_r.grace_expired));
endmodule
`default_nettype wire

// file: dv/mss_partner.sv
`timescale 1ns/10ps
`default_nettype none
module mss_partner #(
  parameter int unsigned DLY = 3,
  parameter logic [31:0] SERIAL = 32'h5A5A1234
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the sequencer.
  input wire logic scan_req_i,
  input wire logic fw_start_i,
  input wire logic fac_reset_i,
  // Card contents and fault settings.
  input wire logic [15:0] ver_i,
  input wire logic bad_name_i,
  input wire logic bad_xfer_i,
  input wire logic bad_ram_i,
  // Answers.
  output logic scan_done_o,
  output mss_pkg::mss_card_type card_o,
  output mss_pkg::mss_engine_type eng_o
);
  import mss_pkg::*;
  // Package name of this revision; a bad name has a letter among the digits.
  localparam logic [63:0] NAME = {CHAR_P, CHAR_B, 48'h303030303031};
  int scan_cnt;
  int xfer_cnt;
  int ram_cnt;
  // Every request is answered after a delay; the loader is the slow one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scan_cnt <= 0;
      xfer_cnt <= 0;
      ram_cnt <= 0;
      scan_done_o <= 1'b0;
      eng_o <= '0;
    end
    else
    begin
      scan_cnt <= scan_req_i ? DLY : (scan_cnt > 0 ? scan_cnt - 1 : 0);
      xfer_cnt <= fw_start_i ? 40 * DLY : (xfer_cnt > 0 ? xfer_cnt - 1 : 0);
      ram_cnt <= fac_reset_i ? DLY : (ram_cnt > 0 ? ram_cnt - 1 : 0);
      scan_done_o <= scan_cnt == 1;
      eng_o.xfer_done <= xfer_cnt == 1;
      eng_o.xfer_err <= xfer_cnt == 1 && bad_xfer_i;
      eng_o.ram_done <= ram_cnt == 1;
      eng_o.ram_ok <= ram_cnt == 1 && !bad_ram_i;
    end
  end
  // Name and version are only valid beside the scan answer; elsewhere they are inverted.
  assign card_o = {scan_done_o ? (bad_name_i ? NAME ^ 64'h40 : NAME) : ~NAME,
                   scan_done_o ? ver_i : ~ver_i, SERIAL};
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mss_pkg::*;
  localparam logic [31:0] SERIAL = 32'h5A5A1234;
  logic clk, rst, sw_run, sw_mres, card_in, cmd_fac, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [15:0] ver, fcode;
  logic bad_name, bad_xfer, bad_ram, scan_req, scan_done, fw_start, ovr, fac;
  logic red, yel, run, feat;
  logic [6:0] st_addr;
  logic [31:0] ip;
  mss_card_type card;
  mss_engine_type eng;
  logic [31:0] r_on, y_on, neq, r_ed, y_ed;
  int err_total = 0;
  int check_count = 0;
  // Clock generation.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Sequencer with shortened tick, debounce and grace period.
  mss_sequencer #(.QTR_CYCLES(4), .DEB_CYCLES(2), .GRACE_SECONDS(3)) u_dut (
    .clk_i(clk), .rst_i(rst), .sw_run_i(sw_run), .sw_mres_i(sw_mres),
    .card_present_i(card_in), .scan_req_o(scan_req), .scan_done_i(scan_done),
    .card_i(card), .fw_start_o(fw_start), .ovr_reset_o(ovr), .fac_reset_o(fac),
    .eng_i(eng), .cmd_factory_i(cmd_fac), .led_red_o(red), .led_yellow_o(yel),
    .cpu_run_o(run), .feat_active_o(feat), .feature_set_code_o(fcode),
    .station_bus_address_o(st_addr), .programming_channel_ip_o(ip), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  // Card reader and engines.
  mss_partner #(.DLY(3), .SERIAL(SERIAL)) u_card (
    .clk_i(clk), .rst_i(rst), .scan_req_i(scan_req), .fw_start_i(fw_start),
    .fac_reset_i(fac), .ver_i(ver), .bad_name_i(bad_name), .bad_xfer_i(bad_xfer),
    .bad_ram_i(bad_ram), .scan_done_o(scan_done), .card_o(card), .eng_o(eng));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      err_total++;
    end
  endtask
  task final_report;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    chk(nm, e, v);
  endtask
  task wait_st(input logic [3:0] s);
    v = 'x;
    for (int i = 0; i < 400 && v[3:0] !== s; i++)
      rd_reg(REG_STATUS);
    chk("state", 32'(s), 32'(v[3:0]));
  endtask
  task wait_pk(input string nm, input int k);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 200 && hit !== 1'b1; i++)
    begin
      @(posedge clk);
      #1 hit = (k == 0) ? fw_start : (k == 1) ? ovr : (k == 2) ? fac : scan_req;
    end
    chk(nm, 32'h1, 32'(hit));
  endtask
  // Counts lit cycles, mismatches and edges of both LEDs over n cycles.
  task watch(input int n);
    logic pr, py;
    @(posedge clk);
    #1 pr = red;
    py = yel;
    {r_on, y_on, neq, r_ed, y_ed} = '0;
    repeat (n)
    begin
      @(posedge clk);
      #1 r_on += 32'(red);
      y_on += 32'(yel);
      neq += 32'(red ^ yel);
      r_ed += 32'(red ^ pr);
      y_ed += 32'(yel ^ py);
      pr = red;
      py = yel;
    end
  endtask
  task sw(input logic r, input logic m, input int n);
    @(posedge clk);
    sw_run <= r;
    sw_mres <= m;
    repeat (n) @(posedge clk);
  endtask
  task tip;
    sw(1'b0, 1'b1, 12);
    sw(1'b0, 1'b0, 0);
  endtask
  task do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Holds the switch at memory reset and lets go during the n-th steady phase.
  task hold(input int n);
    int len, cnt;
    len = 0;
    cnt = 0;
    sw(1'b0, 1'b1, 0);
    for (int i = 0; i < 3000 && cnt < n; i++)
    begin
      @(posedge clk);
      #1 len = (yel === 1'b1) ? len + 1 : 0;
      if (len == 20)
        cnt++;
    end
    sw(1'b0, 1'b0, 0);
  endtask
  // Main sequence.
  initial
  begin
    {rst, sw_run, sw_mres, cmd_fac, wr, rd, bad_name, bad_xfer, bad_ram} = 9'h100;
    card_in = 1'b1;
    addr = '0;
    wdata = '0;
    ver = 16'h0200;
    do_reset(1);
    rd_chk("station", REG_STATION_ADDR, 32'h2);
    rd_chk("prog_ip", REG_PROG_IP, 32'h0);
    rd_chk("fw_ver", REG_FW_VERSION, 32'(FW_VERSION_DEFAULT));
    rd_chk("grace", REG_GRACE_LEFT, 32'h3);
    rd_chk("unmapped", 8'h40, 32'h0);
    wait_st(ST_OFFER);
    watch(64);
    chk("offer_alt", 32'h40, neq);
    tip();
    wait_pk("fw_start", 0);
    chk("upd_ovr", 32'h1, 32'(ovr));
    watch(64);
    chk("busy_red", 32'h0, r_on);
    chk("busy_yel", 32'h10, y_ed);
    wait_st(ST_UPD_OK);
    watch(64);
    chk("ok_pair", 32'h0, neq);
    chk("ok_rate", 32'h8, r_ed);
    bad_xfer <= 1'b1;
    do_reset(2);
    wait_st(ST_OFFER);
    tip();
    wait_st(ST_UPD_ERR);
    watch(64);
    chk("err_yel", 32'h0, y_on);
    chk("err_rate", 32'h8, r_ed);
    bad_xfer <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      ver <= i ? 16'h0200 : FW_VERSION_DEFAULT;
      bad_name <= i[0];
      do_reset(2);
      wait_pk("scan_req", 3);
      repeat (20) @(posedge clk);
      rd_reg(REG_STATUS);
      chk("no_offer", 32'(ST_IDLE), 32'(v[3:0]));
    end
    hold(5);
    wait_pk("ovr_reset", 1);
    watch(16);
    chk("wrong_yel", 32'h10, y_on);
    chk("wrong_red", 32'h0, r_on);
    wr_reg(REG_STATION_ADDR, 32'h5);
    wr_reg(REG_PROG_IP, 32'hC0A80001);
    hold(6);
    wait_st(ST_ARMED);
    sw(1'b0, 1'b1, 0);
    wait_pk("fac_reset", 2);
    sw(1'b0, 1'b0, 0);
    repeat (6) @(posedge clk);
    watch(32);
    chk("conf_yel", 32'h8, y_ed);
    chk("conf_red", 32'h0, r_on);
    chk("st_port", 32'h2, 32'(st_addr));
    chk("ip", 32'h0, ip);
    rd_chk("prog_ip", REG_PROG_IP, 32'h0);
    wait_st(ST_FR_DONE);
    watch(64);
    chk("done_pair", 32'h0, neq);
    chk("done_rate", 32'h8, r_ed);
    bad_ram <= 1'b1;
    do_reset(2);
    wait_st(ST_IDLE);
    @(posedge clk);
    cmd_fac <= 1'b1;
    @(posedge clk);
    cmd_fac <= 1'b0;
    #1 chk("fac_reset", 32'h1, 32'(fac));
    wait_pk("ovr_reset", 1);
    bad_ram <= 1'b0;
    wr_reg(REG_FEAT_SERIAL, SERIAL);
    wr_reg(REG_FEAT_CODE, 32'h00A5);
    wr_reg(REG_CTRL, 32'h1);
    #1 chk("ovr_reset", 32'h1, 32'(ovr));
    repeat (2) @(posedge clk);
    #1 chk("feat", 32'h1, 32'(feat));
    chk("code", 32'h00A5, 32'(fcode));
    sw(1'b1, 1'b0, 12);
    card_in <= 1'b0;
    repeat (12) @(posedge clk);
    watch(16);
    chk("grace_red", 32'h2, r_ed);
    repeat (60) @(posedge clk);
    #1 chk("expired", 32'h0, 32'(run));
    rd_chk("grace_left", REG_GRACE_LEFT, 32'h0);
    @(posedge clk) card_in <= 1'b1;
    repeat (12) @(posedge clk);
    watch(16);
    chk("back_red", 32'h0, r_on);
    chk("back_run", 32'h1, 32'(run));
    sw(1'b0, 1'b0, 12);
    wr_reg(REG_FEAT_SERIAL, ~SERIAL);
    wr_reg(REG_CTRL, 32'h1);
    #1 chk("ovr_reset", 32'h1, 32'(ovr));
    repeat (2) @(posedge clk);
    #1 chk("feat_off", 32'h0, 32'(feat));
    final_report();
  end
  // Cuts a hung run short; the tests need well under ten thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
